// >>> shared/segment_pkg.sv
/*
 * constants and carriers for the segment handshake block.
 * assumes a 32-bit apb slave; register byte address is four
 * times the register index.
 */
package segment_pkg;

    // ********************************************
    // register indices
    // ********************************************
    localparam logic [9:0] IDX_TX_BYTE_COUNT = 10'h077;
    localparam logic [9:0] IDX_TX_SEQ        = 10'h078;
    localparam logic [9:0] IDX_RX_ACK        = 10'h079;
    localparam logic [9:0] IDX_STAT_CLR      = 10'h07a;
    localparam logic [9:0] IDX_FLUSH         = 10'h07b;
    localparam logic [9:0] IDX_TX_PAYLOAD    = 10'h07c;
    localparam logic [9:0] IDX_TX_RELEASE    = 10'h07d;
    localparam logic [9:0] IDX_RESERVED      = 10'h07e;
    localparam logic [9:0] IDX_DIAG          = 10'h07f;
    localparam logic [9:0] IDX_HDR_MODE      = 10'h080;
    localparam logic [9:0] IDX_TX_PAYLOAD_HI = 10'h090;
    localparam logic [9:0] IDX_LINK_STATUS   = 10'h091;

    // ********************************************
    // field positions
    // ********************************************
    localparam int FLUSH_TX_BIT    = 0;
    localparam int FLUSH_RX_BIT    = 1;
    localparam int DIAG_PARAM_BIT  = 3;
    localparam int DIAG_HW_BIT     = 4;
    localparam int DIAG_HSHK_BIT   = 5;
    localparam int DIAG_FRAME_BIT  = 6;
    localparam int DIAG_OVF_BIT    = 7;
    localparam int LS_STAT_BIT     = 0;
    localparam int LS_LOST_BIT     = 1;
    localparam int LS_RXSEQ_LO     = 2;
    localparam int LS_TXACK_LO     = 4;

    // ********************************************
    // reset values and sizes
    // ********************************************
    localparam logic [1:0] SEQ_RESET       = 2'h0;
    localparam logic [3:0] USER_BYTES_HDR1 = 4'h7;
    localparam logic [3:0] USER_BYTES_HDR2 = 4'h6;
    localparam logic [3:0] MAX_BYTE_COUNT  = 4'h7;
    localparam logic [7:0] DIAG_RSVD_MASK  = 8'hf8;

    // outgoing segment toward the serial side
    typedef struct packed {
        logic [63:0] data;
        logic [3:0]  count;
        logic [1:0]  seq;
    } tx_seg_type;

    // fault levels from the serial engine
    typedef struct packed {
        logic param_err;
        logic hw_fail;
        logic hshk_err;
        logic frame_err;
        logic rx_ovf;
        logic disturbed;
    } fault_type;

endpackage : segment_pkg

// >>> src/segment_handshake.sv
/*
 * apb register slave and segment handshake logic for a serial
 * i/o module: sequence counts, acknowledges, status clear,
 * buffer flush, diagnostics and header size mode.
 * assumes the serial engine runs on pclk and drives fault
 * levels and one-cycle segment strobes synchronously.
 * the host reaches every register as one aligned 32-bit word;
 * the byte address is four times the register index.
 * the serial engine owns the buffers themselves: this block
 * only issues the flush pulses and the release strobe.
 */
// Operation
// RL1: host advances tx sequence count each segment
// RL2: sequence gap flags lost segments
// RL3: host echoes latest rx sequence count
// RL4: falling clear request restores status flag
// RL5: clear request low ignores count writes
// RL6: flush accepted only while clear request low
// RL7: bit0 flushes transmit, bit1 flushes receive
// RL8: eight byte transmit payload held
// RL9: release write loads and sends immediately
// RL10: diag bit3 flags unsupported parameters
// RL11: diag bit4 flags hardware failure
// RL12: diag bit5 flags handshake error
// RL13: diag bit6 flags frame error
// RL14: diag bit7 flags receive overflow
// RL15: diag bits 0-2, high byte read zero
// RL16: mode 0 one byte header, 7 bytes
// RL17: mode 1 two byte header, 6 bytes
// RL18: status flag low while link disturbed
// RL19: rx sequence count advances each input segment
// RL20: tx ack echoes sent segment's sequence
// RL21: flush acts once on rising bit edge
module segment_handshake
    import segment_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire fault_type   faults,
    input  wire logic        rx_seg_strobe,
    input  wire logic        tx_seg_done,
    output tx_seg_type       tx_seg,
    output logic             tx_seg_strobe,
    output logic             tx_flush,
    output logic             rx_flush,
    output logic      [15:0] in_header,
    output logic      [3:0]  user_bytes,
    output logic             diag_in_header
);

    // ********************************************
    // state
    // ********************************************
    // apb answer: pready and pslverr last one cycle, prdata two
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;

    // host-written controls
    logic [3:0]  tx_cnt_q;
    logic [1:0]  tx_seq_q;
    logic [1:0]  rx_ack_q;
    logic        clr_req_q;
    logic [7:0]  flush_q;
    logic [63:0] payload_q;
    logic        hdr_mode_q;

    // link condition seen by the host
    logic        stat_q;
    logic        lost_q;
    logic [1:0]  rx_seq_q;
    logic [1:0]  sent_seq_q;
    logic [1:0]  tx_ack_q;
    logic [7:0]  diag_q;

    // registered outputs toward the serial side and the header
    tx_seg_type  tx_seg_q;
    logic        tx_strobe_q;
    logic        tx_flush_q;
    logic        rx_flush_q;
    logic [15:0] in_header_q;
    logic [3:0]  user_bytes_q;
    logic        diag_hdr_q;

    // ********************************************
    // bus decode
    // ********************************************
    // word index match: the two low address bits never select,
    // so a misaligned address still lands on its word
    function automatic logic hit(input logic [11:0] a,
                                 input logic [9:0] idx);
        hit = (a[11:2] == idx);
    endfunction : hit

    // a transfer completes at the edge that sees pready high;
    // every write below is qualified by that edge only
    wire access   = psel & penable;
    wire done     = access & pready_q;
    wire wr_done  = done & pwrite;

    // one select per register slot
    wire h_cnt    = hit(paddr, IDX_TX_BYTE_COUNT);
    wire h_seq    = hit(paddr, IDX_TX_SEQ);
    wire h_ack    = hit(paddr, IDX_RX_ACK);
    wire h_clr    = hit(paddr, IDX_STAT_CLR);
    wire h_flush  = hit(paddr, IDX_FLUSH);
    wire h_pay    = hit(paddr, IDX_TX_PAYLOAD);
    wire h_rel    = hit(paddr, IDX_TX_RELEASE);
    wire h_rsvd   = hit(paddr, IDX_RESERVED);
    wire h_diag   = hit(paddr, IDX_DIAG);
    wire h_mode   = hit(paddr, IDX_HDR_MODE);
    wire h_pay_hi = hit(paddr, IDX_TX_PAYLOAD_HI);
    wire h_link   = hit(paddr, IDX_LINK_STATUS);
    // unmapped slots answer with pslverr and change nothing
    wire mapped   = h_cnt | h_seq | h_ack | h_clr | h_flush
                  | h_pay | h_rel | h_rsvd | h_diag | h_mode
                  | h_pay_hi | h_link;

    // count writes only count while clear request is high
    wire cnt_open = clr_req_q;                       // [RL5]
    wire wr_cnt   = wr_done & h_cnt & cnt_open;      // [RL5]
    wire wr_seq   = wr_done & h_seq & cnt_open;      // [RL5]
    wire wr_ack   = wr_done & h_ack & cnt_open;      // [RL5]

    // the remaining writes are always taken
    wire wr_clr   = wr_done & h_clr;
    wire wr_flush = wr_done & h_flush;
    wire wr_pay   = wr_done & h_pay;
    wire wr_rel   = wr_done & h_rel;
    wire wr_mode  = wr_done & h_mode;
    wire wr_payhi = wr_done & h_pay_hi;

    // ********************************************
    // derived controls
    // ********************************************
    // clear request falling edge restores status
    wire clr_fall  = wr_clr & clr_req_q & ~pwdata[0];  // [RL4]
    // next expected host sequence, wraps 3 -> 0
    wire [1:0] seq_expect = tx_seq_q + 2'h1;          // [RL1]
    // a refused sequence write cannot raise the gap flag
    wire seq_gap   = wr_seq & (pwdata[1:0] != seq_expect); // [RL2]
    // flush edge only counts with clear request low
    wire [7:0] flush_rise = pwdata[7:0] & ~flush_q;   // [RL21]
    wire flush_ok  = wr_flush & ~clr_req_q;           // [RL6]
    wire do_txf    = flush_ok & flush_rise[FLUSH_TX_BIT]; // [RL7]
    wire do_rxf    = flush_ok & flush_rise[FLUSH_RX_BIT]; // [RL7]
    // byte counts above the segment size are clipped
    wire [3:0] cnt_clip = (pwdata[3:0] > MAX_BYTE_COUNT)
                        ? MAX_BYTE_COUNT : pwdata[3:0];
    // sticky fault bits, lined up on bits 7 down to 4
    wire [7:0] diag_set = {faults.rx_ovf,             // [RL14]
                           faults.frame_err,          // [RL13]
                           faults.hshk_err,           // [RL12]
                           faults.hw_fail,            // [RL11]
                           4'h0};
    wire [7:0] diag_d;

    // param error is live; the rest latch until cleared
    // so a short fault is not missed by a slow poll
    assign diag_d[DIAG_PARAM_BIT] = faults.param_err; // [RL10]
    assign diag_d[DIAG_OVF_BIT:DIAG_HW_BIT] =
        diag_set[DIAG_OVF_BIT:DIAG_HW_BIT]
        | (diag_q[DIAG_OVF_BIT:DIAG_HW_BIT] & {4{~clr_fall}});
    assign diag_d[2:0] = 3'h0;                        // [RL15]

    // ********************************************
    // read mux
    // ********************************************
    // link status word: stat, lost, rx seq, tx ack from bit 0 up
    wire [31:0] link_word = {26'h0, tx_ack_q, rx_seq_q,
                             lost_q, stat_q};

    // write-only, reserved and unmapped slots read as zero
    wire [31:0] rd_data =
          h_cnt    ? {28'h0, tx_cnt_q}
        : h_seq    ? {30'h0, tx_seq_q}
        : h_ack    ? {30'h0, rx_ack_q}
        : h_clr    ? {31'h0, clr_req_q}
        : h_flush  ? {24'h0, flush_q}
        : h_pay    ? payload_q[31:0]
        : h_pay_hi ? payload_q[63:32]
        : h_diag   ? {24'h0, diag_q & DIAG_RSVD_MASK} // [RL15]
        : h_mode   ? {31'h0, hdr_mode_q}
        : h_link   ? link_word
        : 32'h0;

    // ********************************************
    // input header and user size
    // ********************************************
    // status byte: stat, lost, rx seq, tx ack
    wire [7:0] stat_byte = link_word[7:0];
    wire [15:0] hdr_d = hdr_mode_q
        ? {diag_q, stat_byte}                         // [RL17]
        : {8'h00, stat_byte};                         // [RL16]
    wire [3:0] ub_d = hdr_mode_q ? USER_BYTES_HDR2    // [RL17]
                                 : USER_BYTES_HDR1;   // [RL16]

    // ********************************************
    // apb answer: one wait state in the access phase
    // ********************************************
    // pready drops after each answer, which forces the single
    // wait state and keeps a held request from completing on two edges in a row
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= access & ~pready_q;
            prdata_q  <= (access & ~pwrite) ? rd_data : 32'h0;
            pslverr_q <= access & ~pready_q & ~mapped;
        end
    end

    // host control registers
    // count writes are already gated by the clear request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt_q   <= 4'h0;
            rx_ack_q   <= SEQ_RESET;
            clr_req_q  <= 1'b0;
            flush_q    <= 8'h00;
            hdr_mode_q <= 1'b0;
        end else begin
            if (wr_cnt)
                tx_cnt_q <= cnt_clip;
            if (wr_ack)
                rx_ack_q <= pwdata[1:0];              // [RL3]
            if (wr_clr)
                clr_req_q <= pwdata[0];
            if (wr_flush)
                flush_q <= pwdata[7:0];
            if (wr_mode)
                hdr_mode_q <= pwdata[0];
        end
    end

    // host sequence count and gap detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_seq_q <= SEQ_RESET;
            lost_q   <= 1'b0;
        end else begin
            if (wr_seq)
                tx_seq_q <= pwdata[1:0];
            // set wins over a clear in the same cycle
            lost_q <= seq_gap | (lost_q & ~clr_fall); // [RL2]
        end
    end

    // payload array, eight bytes
    // the low word is shared by the plain and the release slot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            payload_q <= 64'h0;
        end else if (wr_pay | wr_rel) begin
            payload_q[31:0] <= pwdata;                // [RL8]
        end else if (wr_payhi) begin
            payload_q[63:32] <= pwdata;               // [RL8]
        end
    end

    // status flag: disturbance drops it, clear edge raises it
    // a disturbance that persists keeps the flag low through a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 1'b1;
        end else if (faults.disturbed) begin
            stat_q <= 1'b0;                           // [RL18]
        end else if (clr_fall) begin
            stat_q <= 1'b1;                           // [RL4]
        end
    end

    // diagnostic byte
    // reserved bits are forced low in diag_d, not only masked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            diag_q <= 8'h00;
        else
            diag_q <= diag_d;
    end

    // device sequence counts
    // the rx count wraps at four by its width alone; tx ack copies sent_seq_q
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_seq_q <= SEQ_RESET;
            tx_ack_q <= SEQ_RESET;
        end else begin
            if (rx_seg_strobe)
                rx_seq_q <= rx_seq_q + 2'h1;          // [RL19]
            if (tx_seg_done)
                tx_ack_q <= sent_seq_q;               // [RL20]
        end
    end

    // release: load and send in one step
    // the high word must be written before the release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_seg_q    <= '0;
            tx_strobe_q <= 1'b0;
            sent_seq_q  <= SEQ_RESET;
        end else begin
            tx_strobe_q <= wr_rel;                    // [RL9]
            if (wr_rel) begin
                tx_seg_q.data  <= {payload_q[63:32], pwdata}; // [RL9]
                tx_seg_q.count <= tx_cnt_q;
                tx_seg_q.seq   <= tx_seq_q;
                sent_seq_q     <= tx_seq_q;           // [RL20]
            end
        end
    end

    // flush pulses and header outputs
    // mode flag is registered with the header so all three
    // outputs switch on the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_flush_q   <= 1'b0;
            rx_flush_q   <= 1'b0;
            in_header_q  <= 16'h0001;
            user_bytes_q <= USER_BYTES_HDR1;
            diag_hdr_q   <= 1'b0;
        end else begin
            tx_flush_q   <= do_txf;                   // [RL21]
            rx_flush_q   <= do_rxf;                   // [RL21]
            in_header_q  <= hdr_d;
            user_bytes_q <= ub_d;
            diag_hdr_q   <= hdr_mode_q;               // [RL17]
        end
    end

    // ********************************************
    // outputs
    // ********************************************
    // every output is a flip-flop; header, user size and mode
    // flag trail a mode write by one edge, together
    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign tx_seg         = tx_seg_q;
    assign tx_seg_strobe  = tx_strobe_q;
    assign tx_flush       = tx_flush_q;
    assign rx_flush       = rx_flush_q;
    assign in_header      = in_header_q;
    assign user_bytes     = user_bytes_q;
    assign diag_in_header = diag_hdr_q;               // [RL17]

endmodule : segment_handshake

// >>> testbench/serial_engine_model.sv
/*
 * serial engine stand-in: reports a released segment as sent unless a new release restarts the count first.
 * assumes the strobe is a one-cycle pulse on pclk; lat is 1..15.
 */
module serial_engine_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tx_seg_strobe,
    input  wire logic [3:0] lat,
    output logic            tx_seg_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************************
    // send delay
    // ********************************************
    logic [3:0] cnt_q;

    // a new release restarts the count, as a real line would drop the old frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q       <= 4'h0;
            tx_seg_done <= 1'b0;
        end else begin
            tx_seg_done <= (cnt_q == 4'h1);
            cnt_q       <= tx_seg_strobe ? lat : (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
        end
    end
endmodule : serial_engine_model

// >>> testbench/segment_handshake_properties.sv
/*
 * concurrent checks on the segment handshake ports.
 * assumes a master that holds each request until pready.
 */
module segment_handshake_properties
    import segment_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire fault_type   faults,
    input wire logic        rx_seg_strobe,
    input wire logic        tx_seg_done,
    input wire tx_seg_type  tx_seg,
    input wire logic        tx_seg_strobe,
    input wire logic        tx_flush,
    input wire logic        rx_flush,
    input wire logic [15:0] in_header,
    input wire logic [3:0]  user_bytes,
    input wire logic        diag_in_header
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************************
    // checks
    // ********************************************
    localparam logic [11:0] A_FLUSH = {IDX_FLUSH, 2'b00};
    localparam logic [11:0] A_REL   = {IDX_TX_RELEASE, 2'b00};
    wire wacc = psel && penable && pready && pwrite;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup; psel && !penable; endsequence
    sequence s_wait; psel && penable && !pready ##1 psel && penable && pready; endsequence

    chk_apb_wait: assert property (s_setup |=> s_wait) else $error("apb wait state wrong");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready not a pulse");
    chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    chk_tx_flush_cause: assert property (tx_flush |-> $past(wacc && paddr == A_FLUSH && pwdata[0]))
        else $error("tx flush without bit 0 write");
    chk_rx_flush_cause: assert property (rx_flush |-> $past(wacc && paddr == A_FLUSH && pwdata[1]))
        else $error("rx flush without bit 1 write");
    chk_release_seg: assert property (wacc && paddr == A_REL |=> tx_seg_strobe
        && tx_seg.data[31:0] == $past(pwdata)) else $error("release not sent at once");
    chk_strobe_cause: assert property (tx_seg_strobe |-> $past(wacc && paddr == A_REL))
        else $error("segment strobe without release");
    chk_user_bytes: assert property (user_bytes == (diag_in_header ? 4'h6 : 4'h7))
        else $error("user byte count wrong");
    chk_hdr_short: assert property (!diag_in_header |-> in_header[15:8] == 8'h00)
        else $error("diag byte in short header");
    chk_diag_rsvd: assert property (in_header[10:8] == 3'h0) else $error("reserved diag set");
    chk_stat_low: assert property (faults.disturbed |-> ##[1:2] !in_header[0])
        else $error("status flag high while disturbed");
    chk_param_live: assert property ((faults.param_err && diag_in_header)[*3] |-> in_header[11])
        else $error("parameter error not shown");
endmodule : segment_handshake_properties

bind segment_handshake segment_handshake_properties u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .faults(faults), .rx_seg_strobe(rx_seg_strobe), .tx_seg_done(tx_seg_done),
    .tx_seg(tx_seg), .tx_seg_strobe(tx_seg_strobe), .tx_flush(tx_flush), .rx_flush(rx_flush),
    .in_header(in_header), .user_bytes(user_bytes), .diag_in_header(diag_in_header));

// >>> testbench/testbench.sv
/*
 * self-checking bench: apb host, fault stimulus, serial engine model.
 * assumes the checker is bound from its own file.
 */
module testbench import segment_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************************
    // stimulus and checking
    // ********************************************
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_seg_strobe = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rq, lo, hi;
    logic        pready, pslverr, rerr, tx_seg_strobe, tx_flush, rx_flush, diag_in_header;
    logic        tx_seg_done;
    logic [3:0]  user_bytes, lat = 4'h1;
    logic [15:0] in_header;
    logic [1:0]  s = 0;
    tx_seg_type  tx_seg;
    fault_type   faults = '0;
    int          n_errors = 0, check_count = 0, cyc = 0, n_tx = 0, n_rx = 0, n_str = 0, n;
    int          seed = 32'hdaf4d1cc;

    always #12.5 pclk = ~pclk;

    segment_handshake u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .faults(faults), .rx_seg_strobe(rx_seg_strobe),
        .tx_seg_done(tx_seg_done), .tx_seg(tx_seg), .tx_seg_strobe(tx_seg_strobe),
        .tx_flush(tx_flush), .rx_flush(rx_flush), .in_header(in_header),
        .user_bytes(user_bytes), .diag_in_header(diag_in_header));
    serial_engine_model u_eng (.pclk(pclk), .presetn(presetn), .tx_seg_strobe(tx_seg_strobe),
        .lat(lat), .tx_seg_done(tx_seg_done));

    // pulse counters and hang guard
    always @(posedge pclk) begin
        cyc++;
        n_tx += (tx_flush === 1'b1);
        n_rx += (rx_flush === 1'b1);
        n_str += (tx_seg_strobe === 1'b1);
        if (cyc == 6000) begin
            n_errors++;
            stop_test();
        end
    end

    function automatic logic [11:0] ad(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction : ad
    function automatic logic [63:0] link_exp(input logic st, lost, input logic [1:0] rx, tk);
        return {58'h0, tk, rx, lost, st};
    endfunction : link_exp

    task automatic chk(input string nm, input logic [63:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // held until pready, released after the sampling edge only
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 16) begin
            @(posedge pclk);
            k++;
        end
        if (k == 16) n_errors++;
        rq = prdata;
        rerr = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask : apb
    task automatic w(input logic [9:0] i, input logic [31:0] d); apb(1, ad(i), d); endtask : w
    task automatic r(input logic [9:0] i); apb(0, ad(i), 0); endtask : r
    task automatic clr_pulse(); w(IDX_STAT_CLR, 1); w(IDX_STAT_CLR, 0); endtask : clr_pulse
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        r(IDX_LINK_STATUS);
        chk("link", rq, link_exp(1, 0, 0, 0));
        chk("ub", user_bytes, 7);
        w(IDX_HDR_MODE, 1);
        repeat (2) @(posedge pclk);
        chk("ub", {user_bytes, diag_in_header}, {4'h6, 1'b1});
        w(IDX_TX_SEQ, 1);
        w(IDX_RX_ACK, 2);
        w(IDX_TX_BYTE_COUNT, 3);
        r(IDX_TX_SEQ);
        chk("seq", rq[1:0], 0);
        r(IDX_RX_ACK);
        chk("ack", rq[1:0], 0);
        r(IDX_TX_BYTE_COUNT);
        chk("cnt", rq, 0);
        w(IDX_STAT_CLR, 1);
        w(IDX_TX_BYTE_COUNT, 9);
        for (int i = 0; i < 5; i++) begin
            s++;
            w(IDX_TX_SEQ, s);
            lat <= 4'($random(seed) & 7) + 4'h1;
            hi = $random(seed);
            lo = $random(seed);
            w(IDX_TX_PAYLOAD_HI, hi);
            w(IDX_TX_RELEASE, lo);
            repeat (12) @(posedge pclk);
            chk("seg", tx_seg.data, {hi, lo});
            chk("segseq", tx_seg.seq, s);
            chk("count", tx_seg.count, MAX_BYTE_COUNT);
            r(IDX_LINK_STATUS);
            chk("link", rq, link_exp(1, 0, 0, s));
            r(IDX_TX_PAYLOAD);
            chk("pay", rq, lo);
        end
        w(IDX_RX_ACK, 3);
        r(IDX_RX_ACK);
        chk("ack", rq[1:0], 3);
        w(IDX_TX_SEQ, s + 2'h2);
        r(IDX_LINK_STATUS);
        chk("lost", rq[1], 1);
        clr_pulse();
        r(IDX_LINK_STATUS);
        chk("clr", rq[1:0], 2'b01);
        n = ($random(seed) & 7) + 1;
        repeat (n) begin
            rx_seg_strobe <= 1;
            @(posedge pclk);
            rx_seg_strobe <= 0;
            @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
        r(IDX_LINK_STATUS);
        chk("rxseq", rq, link_exp(1, 0, 2'(n), s));
        chk("hdr", in_header, link_exp(1, 0, 2'(n), s));
        w(IDX_FLUSH, 1); w(IDX_FLUSH, 1); w(IDX_FLUSH, 0); w(IDX_FLUSH, 2); w(IDX_FLUSH, 3);
        w(IDX_STAT_CLR, 1); w(IDX_FLUSH, 0); w(IDX_FLUSH, 3); w(IDX_STAT_CLR, 0);
        chk("flush", {n_tx, n_rx}, {32'd2, 32'd1});
        for (int b = 0; b < 5; b++) begin
            faults <= fault_type'(6'h20 >> b);
            repeat (4) @(posedge pclk);
            r(IDX_DIAG);
            chk("diag", {rq, in_header[15:8]}, {32'h8 << b, 8'h8 << b});
            faults <= '0;
            repeat (4) @(posedge pclk);
            r(IDX_DIAG);
            chk("sticky", rq, (b == 0) ? 0 : 32'h8 << b);
            clr_pulse();
            r(IDX_DIAG);
            chk("dclr", rq, 0);
        end
        faults <= 6'h01;
        repeat (4) @(posedge pclk);
        r(IDX_LINK_STATUS);
        chk("dist", rq[0], 0);
        faults <= '0;
        repeat (4) @(posedge pclk);
        r(IDX_LINK_STATUS);
        chk("hold", rq[0], 0);
        clr_pulse();
        r(IDX_LINK_STATUS);
        chk("rest", rq[0], 1);
        apb(0, 12'h300, 0);
        chk("unmap", {rerr, rq}, {1'b1, 32'h0});
        r(IDX_RESERVED);
        chk("rsvd", {rerr, rq}, 0);
        w(IDX_HDR_MODE, 0);
        repeat (2) @(posedge pclk);
        chk("short", {in_header[15:8], user_bytes}, {8'h0, 4'h7});
        chk("strobes", n_str, 5);
        stop_test();
    end
endmodule : testbench
